// file: pkg/mhbi_pkg.sv
// Constants and types shared by the multiplexed host bus interface
`default_nettype none
package mhbi_pkg;

	// Widths
	localparam int DATA_W      = 8;
	localparam int SYNC_STAGES = 2;

	// Positions of the pins inside the synchroniser vector
	localparam int S_AS  = 0;
	localparam int S_DS  = 1;
	localparam int S_RW  = 2;
	localparam int S_CSN = 3;
	localparam int S_STY = 4;
	localparam int S_PF  = 5;
	localparam int S_BUS = 6;
	localparam int SYNC_W = S_BUS + DATA_W;

	// Reset values
	localparam logic [7:0]  ADDR_RST = 8'h00;
	localparam logic [7:0]  DATA_RST = 8'h00;
	// Select and write line idle high, everything else low
	localparam logic [13:0] SYNC_RST = 14'h000c;

	// Read sequencer states
	typedef enum logic [1:0]
	{
		MHBI_IDLE  = 2'b00,
		MHBI_FETCH = 2'b01,
		MHBI_LOAD  = 2'b11,
		MHBI_DRIVE = 2'b10
	} mhbi_state_t;

	// Complete state of the interface
	typedef struct packed
	{
		mhbi_state_t st;
		logic [7:0]  addr;
		logic        addr_vld;
		logic [7:0]  rdat;
		logic [7:0]  wdat;
		logic        wr;
		logic        rd;
		logic        as_d;
		logic        ds_d;
		logic        rw_d;
	} mhbi_regs_t;

endpackage
`default_nettype wire

// file: design/mhbi_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
`default_nettype none
module mhbi_sync
#(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
)
(
	input  wire logic         clk_sys_in,  // System clock
	input  wire logic         rst_in,      // Async reset, high
	input  wire logic [W-1:0] async_in,    // Raw pin levels
	output logic      [W-1:0] sync_out     // Synchronised levels
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] stable_reg;
	logic [W-1:0] stable_next;

	// First stage is read only by the second
	always_comb
	begin
		meta_next   = async_in;
		stable_next = meta_reg;
	end

	// Both stages reset to the idle pin levels
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			meta_reg   <= RST;
			stable_reg <= RST;
		end
		else
		begin
			meta_reg   <= meta_next;
			stable_reg <= stable_next;
		end
	end

	assign sync_out = stable_reg;

endmodule // mhbi_sync
`default_nettype wire

// file: design/mhbi_host_port.sv
// Device end of the multiplexed byte-wide host bus interface
`timescale 1ns/10ps
`default_nettype none
module mhbi_host_port
(
	input  wire logic       clk_sys_in,           // 200 MHz clock
	input  wire logic       rst_in,               // Async reset, high
	input  wire logic       bus_style_select_in,  // High: data strobe style
	input  wire logic       address_strobe_in,    // Address strobe pin
	input  wire logic       data_strobe_in,       // Data strobe pin
	input  wire logic       rw_in,                // Read/write pin
	input  wire logic       cs_n_in,              // Chip select, low
	input  wire logic       power_fail_in,        // Supply below threshold
	input  wire logic [7:0] shared_addr_data_bus_in,   // Bus pin level
	output logic      [7:0] shared_addr_data_bus_out,  // Read data
	output logic            shared_addr_data_bus_oe_n_out, // Low: drive
	output logic      [7:0] reg_addr_out,         // Access address
	output logic      [7:0] reg_wdata_out,        // Write data
	output logic            reg_wr_out,           // Write pulse
	output logic            reg_rd_out,           // Read pulse
	input  wire logic [7:0] reg_rdata_in          // Read data, next cycle
);

	mhbi_pkg::mhbi_regs_t r_reg;
	mhbi_pkg::mhbi_regs_t r_next;

	logic [mhbi_pkg::SYNC_W-1:0] pins_raw;
	logic [mhbi_pkg::SYNC_W-1:0] pins;

	logic       as_lvl;
	logic       ds_lvl;
	logic       rw_lvl;
	logic       style_ds;
	logic       sel;
	logic [7:0] bus;
	logic       as_fall;
	logic       as_rise;
	logic       ds_fall;
	logic       ds_rise;
	logic       rw_rise;
	logic       read_lvl;
	logic       read_end;
	logic       wr_evt;
	logic       idle;

	// Bus data travels with the strobes so both see the same delay
	assign pins_raw = {shared_addr_data_bus_in, power_fail_in,
		bus_style_select_in, cs_n_in, rw_in, data_strobe_in,
		address_strobe_in};

	// All pins cross into the clock domain before use
	mhbi_sync
	#(
		.W   (mhbi_pkg::SYNC_W),
		.RST (mhbi_pkg::SYNC_RST)
	)
	u_sync
	(
		.clk_sys_in (clk_sys_in),
		.rst_in     (rst_in),
		.async_in   (pins_raw),
		.sync_out   (pins)
	);

	// Synchronised levels
	assign as_lvl   = pins[mhbi_pkg::S_AS];
	assign ds_lvl   = pins[mhbi_pkg::S_DS];
	assign rw_lvl   = pins[mhbi_pkg::S_RW];
	// Floating pin reads low through the pad pulldown
	assign style_ds = pins[mhbi_pkg::S_STY];
	assign bus      = pins[mhbi_pkg::S_BUS +: mhbi_pkg::DATA_W];

	// Power fail masks the select before anything sees it
	assign sel = ~pins[mhbi_pkg::S_CSN] & ~pins[mhbi_pkg::S_PF];

	// Edges from the previous synchronised sample
	assign as_fall = r_reg.as_d & ~as_lvl;
	assign as_rise = ~r_reg.as_d & as_lvl;
	assign ds_fall = r_reg.ds_d & ~ds_lvl;
	assign ds_rise = ~r_reg.ds_d & ds_lvl;
	assign rw_rise = ~r_reg.rw_d & rw_lvl;

	assign idle = (r_reg.st == mhbi_pkg::MHBI_IDLE);

	// Read window and its end per timing style
	always_comb
	begin
		if (style_ds)
		begin
			read_lvl = ds_lvl & rw_lvl;
			read_end = ds_fall;
			wr_evt   = ds_fall & ~rw_lvl;
		end
		else
		begin
			read_lvl = ~ds_lvl & rw_lvl;
			read_end = ds_rise;
			wr_evt   = rw_rise;
		end
	end

	// Next state of the whole interface
	always_comb
	begin
		r_next      = r_reg;
		r_next.wr   = 1'b0;
		r_next.rd   = 1'b0;
		r_next.as_d = as_lvl;
		r_next.ds_d = ds_lvl;
		r_next.rw_d = rw_lvl;

		// Address latch is independent of select
		if (as_rise)
		begin
			r_next.addr     = mhbi_pkg::ADDR_RST;
			r_next.addr_vld = 1'b0;
		end
		else if (as_fall)
		begin
			r_next.addr     = bus;
			r_next.addr_vld = 1'b1;
		end

		// A data phase uses up the address, selected or not
		if (wr_evt && r_reg.addr_vld && idle)
		begin
			r_next.addr_vld = 1'b0;
			if (sel)
			begin
				r_next.wr   = 1'b1;
				r_next.wdat = bus;
			end
		end

		// Read sequencer; core answers one cycle after the pulse
		unique case (r_reg.st)
			mhbi_pkg::MHBI_IDLE:
			begin
				if (read_lvl && r_reg.addr_vld)
				begin
					r_next.addr_vld = 1'b0;
					if (sel)
					begin
						r_next.rd = 1'b1;
						r_next.st = mhbi_pkg::MHBI_FETCH;
					end
				end
			end
			mhbi_pkg::MHBI_FETCH:
			begin
				r_next.st = mhbi_pkg::MHBI_LOAD;
			end
			mhbi_pkg::MHBI_LOAD:
			begin
				r_next.rdat = reg_rdata_in;
				r_next.st   = mhbi_pkg::MHBI_DRIVE;
			end
			mhbi_pkg::MHBI_DRIVE:
			begin
				r_next.st = mhbi_pkg::MHBI_DRIVE;
			end
		endcase

		// Loss of window or select aborts; relies on host holding it
		if (!idle && (read_end || !read_lvl || !sel))
		begin
			r_next.st = mhbi_pkg::MHBI_IDLE;
		end
	end

	// State register
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			r_reg          <= '0;
			r_reg.st       <= mhbi_pkg::MHBI_IDLE;
			r_reg.addr     <= mhbi_pkg::ADDR_RST;
			r_reg.rdat     <= mhbi_pkg::DATA_RST;
			r_reg.wdat     <= mhbi_pkg::DATA_RST;
			r_reg.rw_d     <= 1'b1;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the state register
	assign shared_addr_data_bus_out      = r_reg.rdat;
	assign shared_addr_data_bus_oe_n_out =
		(r_reg.st != mhbi_pkg::MHBI_DRIVE);
	assign reg_addr_out  = r_reg.addr;
	assign reg_wdata_out = r_reg.wdat;
	assign reg_wr_out    = r_reg.wr;
	assign reg_rd_out    = r_reg.rd;

	// Address capture on falling strobe, select ignored
	a_addr_capture: assert property (@(posedge clk_sys_in)
		disable iff (rst_in)
		as_fall |=> (reg_addr_out == $past(bus)) && r_reg.addr_vld)
		else $error("address not latched");

	// Rising strobe always clears the address
	a_addr_clear: assert property (@(posedge clk_sys_in)
		disable iff (rst_in)
		as_rise |=> (reg_addr_out == 8'h00) && !r_reg.addr_vld)
		else $error("address not cleared");

	// Deselected write leaves the core alone
	a_nocs_noaccess: assert property (@(posedge clk_sys_in)
		disable iff (rst_in)
		(!sel && idle) |=> !reg_wr_out && !reg_rd_out)
		else $error("access while deselected");

	// Power fail blocks access and drive
	a_pfail_block: assert property (@(posedge clk_sys_in)
		disable iff (rst_in)
		pins[mhbi_pkg::S_PF] |=> !reg_wr_out && !reg_rd_out
			&& shared_addr_data_bus_oe_n_out)
		else $error("access during power fail");

	// Data strobe style write on falling strobe
	a_write_ds: assert property (@(posedge clk_sys_in)
		disable iff (rst_in)
		(style_ds && ds_fall && !rw_lvl && sel && r_reg.addr_vld
			&& idle) |=> reg_wr_out && (reg_wdata_out == $past(bus)))
		else $error("data strobe write missed");

	// Strobe style write on rising write line
	a_write_rw: assert property (@(posedge clk_sys_in)
		disable iff (rst_in)
		(!style_ds && rw_rise && sel && r_reg.addr_vld && idle)
			|=> reg_wr_out ##1 !reg_wr_out)
		else $error("write strobe write missed");

	// Drive only inside the read window
	a_drive_window: assert property (@(posedge clk_sys_in)
		disable iff (rst_in)
		!shared_addr_data_bus_oe_n_out |-> $past(read_lvl) && $past(sel))
		else $error("drive outside read window");

	// Read end releases the bus next cycle
	a_read_release: assert property (@(posedge clk_sys_in)
		disable iff (rst_in)
		read_end |=> shared_addr_data_bus_oe_n_out)
		else $error("bus held after read end");

	// Read pulse, core data taken a cycle later, then driven
	a_read_latency: assert property (@(posedge clk_sys_in)
		disable iff (rst_in)
		(idle && read_lvl && r_reg.addr_vld && sel) ##1
			(read_lvl && sel && !read_end)[*2]
			|=> !shared_addr_data_bus_oe_n_out
			&& $past(reg_rd_out, 2)
			&& (shared_addr_data_bus_out == $past(reg_rdata_in)))
		else $error("read sequence wrong");

	// Read pulse lasts one cycle; core must not see a double read
	a_rd_single: assert property (@(posedge clk_sys_in)
		disable iff (rst_in)
		reg_rd_out |=> !reg_rd_out)
		else $error("read pulse too long");

	// Write pulse lasts one cycle; core must not see a double write
	a_wr_single: assert property (@(posedge clk_sys_in)
		disable iff (rst_in)
		reg_wr_out |=> !reg_wr_out)
		else $error("write pulse too long");

	// Strobe style: low data strobe with high write line reads
	a_rw_read_start: assert property (@(posedge clk_sys_in)
		disable iff (rst_in)
		(!style_ds && idle && !ds_lvl && rw_lvl && r_reg.addr_vld
			&& sel) |=> reg_rd_out)
		else $error("read enable missed");

	// Data strobe style: high strobe with read level reads
	a_ds_read_start: assert property (@(posedge clk_sys_in)
		disable iff (rst_in)
		(style_ds && idle && ds_lvl && rw_lvl && r_reg.addr_vld
			&& sel) |=> reg_rd_out)
		else $error("data strobe read missed");

	// Driven data hold still for the whole read window
	a_drive_stable: assert property (@(posedge clk_sys_in)
		disable iff (rst_in)
		(!shared_addr_data_bus_oe_n_out
			&& !$past(shared_addr_data_bus_oe_n_out))
			|-> $stable(shared_addr_data_bus_out))
		else $error("read data changed while driven");

endmodule // mhbi_host_port
`default_nettype wire

// file: test/mhbi_host_model.sv
// Host model driving the multiplexed bus pins
`timescale 1ns/10ps
`default_nettype none
module mhbi_host_model
(
	input  wire logic       clk_in,   // System clock
	input  wire logic [7:0] dev_in,   // Device read data
	input  wire logic       oe_n_in,  // Low: device drives
	output logic      [7:0] bus_out,  // Bus wire level
	output logic            sty_out,  // Bus style pin
	output logic            as_out,   // Address strobe
	output logic            ds_out,   // Data strobe
	output logic            rw_out,   // Read/write pin
	output logic            cs_n_out, // Chip select, low
	output logic            pf_out    // Power fail
);
	logic [7:0] hd;
	logic [7:0] last_reg;
	logic       hen;

	// Released bus toggles, so a stale value never passes
	assign bus_out = !oe_n_in ? dev_in : hen ? hd : ~last_reg;

	// Wire level of the last cycle
	always @(posedge clk_in)
	begin
		last_reg <= bus_out;
	end

	// Idle pins at time zero
	initial
	begin
		{sty_out, as_out, pf_out, hen, hd} = 12'h000;
		{ds_out, rw_out, cs_n_out} = 3'h7;
		last_reg = 8'h00;
	end

	task automatic wt(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	// Rise of the address strobe, held high afterwards
	task automatic as_rise();
		as_out = 1'b1;
		wt(6);
	endtask

	// One bus cycle; pins change only at the falling edge
	task automatic access(input logic s, w, c, p, f,
		input logic [7:0] a, d, output logic [7:0] q);
		q = 8'h00;
		sty_out = s;
		ds_out = !s;
		cs_n_out = c;
		pf_out = p;
		wt(4);
		if (f)
		begin
			as_out = 1'b1;
			hd = a;
			hen = 1'b1;
			wt(4);
			as_out = 1'b0;
			wt(4);
		end
		hd = d;
		hen = w;
		if (s)
		begin
			rw_out = !w;
			wt(2);
			ds_out = 1'b1;
			wt(12);
			q = bus_out;
			ds_out = 1'b0;
		end
		else if (w)
		begin
			rw_out = 1'b0;
			wt(6);
			rw_out = 1'b1;
		end
		else
		begin
			ds_out = 1'b0;
			wt(12);
			q = bus_out;
			ds_out = 1'b1;
		end
		// Data and select held past the strobe edge
		wt(4);
		hen = 1'b0;
		rw_out = 1'b1;
		cs_n_out = 1'b1;
	endtask
endmodule // mhbi_host_model
`default_nettype wire

// file: test/tb_muxed_host_bus_interface.sv
// Self-checking bench for the multiplexed host bus interface
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) \
	begin \
		n_compared++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("Error at %0t: got %h want %h", $time, g, e); \
		end \
	end
module tb_muxed_host_bus_interface;
	logic       clk_sys_in, rst_in, oe_n, wr, rd, sty, as_p, ds, rw;
	logic       cs_n, pf;
	logic [7:0] bus, dout, addr, wdat, rdat, last_wd;
	int         n_mismatch, n_compared, n_wr, n_rd, cyc;

	mhbi_host_port dut
	(
		.clk_sys_in                    (clk_sys_in),
		.rst_in                        (rst_in),
		.bus_style_select_in           (sty),
		.address_strobe_in             (as_p),
		.data_strobe_in                (ds),
		.rw_in                         (rw),
		.cs_n_in                       (cs_n),
		.power_fail_in                 (pf),
		.shared_addr_data_bus_in       (bus),
		.shared_addr_data_bus_out      (dout),
		.shared_addr_data_bus_oe_n_out (oe_n),
		.reg_addr_out                  (addr),
		.reg_wdata_out                 (wdat),
		.reg_wr_out                    (wr),
		.reg_rd_out                    (rd),
		.reg_rdata_in                  (rdat)
	);

	mhbi_host_model host
	(
		.clk_in   (clk_sys_in),
		.dev_in   (dout),
		.oe_n_in  (oe_n),
		.bus_out  (bus),
		.sty_out  (sty),
		.as_out   (as_p),
		.ds_out   (ds),
		.rw_out   (rw),
		.cs_n_out (cs_n),
		.pf_out   (pf)
	);

	// Core contents: a fixed scramble of the address
	function automatic logic [7:0] core_val(input logic [7:0] x);
		return {x[3:0], x[7:4]} ^ 8'ha5;
	endfunction

	initial
	begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end

	// Core stand-in answers the latched address
	always @(negedge clk_sys_in)
		rdat <= core_val(addr);

	// Pulse counts and the hang limit
	always @(posedge clk_sys_in)
	begin
		cyc++;
		if (wr === 1'b1)
		begin
			n_wr++;
			last_wd = wdat;
		end
		if (rd === 1'b1)
			n_rd++;
		if (cyc == 6000)
		begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// One access, then its effects at the core port
	task automatic run(input logic s, w, c, p, f,
		input logic [7:0] a, d);
		int         w0, r0;
		logic [7:0] q;
		logic       go;
		w0 = n_wr;
		r0 = n_rd;
		go = !c && !p && f;
		host.access(s, w, c, p, f, a, d, q);
		repeat (4) @(negedge clk_sys_in);
		`CHK(addr, f ? a : 8'h00)
		`CHK(n_wr - w0, (go && w) ? 1 : 0)
		`CHK(n_rd - r0, (go && !w) ? 1 : 0)
		`CHK(oe_n, 1'b1)
		if (go && w) `CHK(last_wd, d)
		if (go && !w) `CHK(q, core_val(a))
		host.as_rise();
		`CHK(addr, 8'h00)
		$display("Test at %0t done", $time);
	endtask

	initial
	begin
		rst_in = 1'b1;
		{n_mismatch, n_compared, n_wr, n_rd, cyc} = '0;
		void'($urandom(83));
		repeat (2) @(negedge clk_sys_in);
		rst_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		// Corners: both styles, both directions, no access cases
		for (int i = 0; i < 4; i++)
			run(i[0], i[1], 1'b0, 1'b0, 1'b1, 8'hff, 8'h00);
		run(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h3c, 8'hc3);
		run(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h81, 8'h00);
		run(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h5a);
		// Random traffic
		for (int i = 0; i < 40; i++)
			run(1'($urandom_range(1)), 1'($urandom_range(1)),
				$urandom_range(3) == 0, $urandom_range(3) == 0,
				$urandom_range(7) != 0, 8'($urandom), 8'($urandom));
		end_of_test();
	end
endmodule // tb_muxed_host_bus_interface
`default_nettype wire
